// >>> include/afc_map.svh
/*
 * Register indexes, field positions, reset values and sizes of the FIFO
 * scan control block.
 * Assumes a 32-bit APB bus where byte address is four times the index.
 */
`ifndef AFC_MAP_SVH
`define AFC_MAP_SVH

`define AFC_IDX_CTRL_ONE    6'h10
`define AFC_IDX_FIFO_CTRL   6'h13
`define AFC_IDX_RES_HIGH    6'h14
`define AFC_IDX_RES_LOW     6'h15
`define AFC_IDX_IRQ_STATUS  6'h20
`define AFC_IDX_IRQ_MASK    6'h21

`define AFC_FC_SCAN_BIT     6
`define AFC_FC_COMB_BIT     5
`define AFC_FC_DEP_MSB      2
`define AFC_FC_DEP_LSB      0
`define AFC_FC_WRITE_MASK   8'h67
`define AFC_FC_RESET        8'h00

`define AFC_C1_CMP_BIT      6
`define AFC_C1_CONT_BIT     5
`define AFC_C1_CH_MSB       4
`define AFC_C1_CH_LSB       0
`define AFC_C1_RESET        8'h00

`define AFC_IRQ_DONE_BIT    0
`define AFC_IRQ_OVF_BIT     1
`define AFC_IRQ_WIDTH       2

`define AFC_MAX_LEVELS      8
`define AFC_RES_WIDTH       12
`define AFC_CH_WIDTH        5

`endif

// >>> include/afc_pkg.sv
/*
 * Types of the FIFO scan control block.
 * Assumes afc_map.svh is on the include path.
 */
`include "afc_map.svh"

package afc_pkg;

  typedef enum logic [0:0] {
    AFC_ST_IDLE = 1'b0,
    AFC_ST_WAIT = 1'b1
  } afc_state_t;

  typedef struct packed {
    logic                       start;
    logic [`AFC_CH_WIDTH-1:0]   channel;
  } afc_conv_req_t;

  typedef struct packed {
    logic                       done;
    logic                       match;
    logic [`AFC_RES_WIDTH-1:0]  result;
  } afc_conv_rsp_t;

  typedef struct packed {
    afc_state_t                                          state;
    logic [7:0]                                          fifo_ctrl;
    logic [7:0]                                          ctrl_one;
    logic                                                conversion_complete_flag;
    logic [`AFC_IRQ_WIDTH-1:0]                           irq_status;
    logic [`AFC_IRQ_WIDTH-1:0]                           irq_mask;
    logic                                                irq;
    logic [`AFC_MAX_LEVELS-1:0][`AFC_CH_WIDTH-1:0]       ch_mem;
    logic [3:0]                                          ch_cnt;
    logic [2:0]                                          conv_idx;
    logic [`AFC_MAX_LEVELS-1:0][`AFC_RES_WIDTH-1:0]      res_mem;
    logic [3:0]                                          res_cnt;
    logic [2:0]                                          res_rd;
    logic                                                match_or;
    logic                                                match_and;
    afc_conv_req_t                                       conv_req;
    logic                                                pready;
    logic                                                pslverr;
    logic [31:0]                                         prdata;
  } afc_state_s_t;

endpackage

// >>> hw/afc_fifo_scan_ctrl.sv
/*
 * FIFO scan control of a successive-approximation converter: channel and
 * result FIFOs, scan mode, OR/AND compare combining, completion flag and
 * interrupt, all behind an APB slave.
 * Assumes the converter core runs on pclk, takes a one-cycle start with a
 * channel and answers with a one-cycle done carrying result and match.
 */
// The APB slave port was chosen for this implementation.
// Functional notes
// - Reserved control bits read zero, ignore writes.
// - Scan mode repeats first queued channel until full.
// - Continuous scan restarts from first queued channel when complete.
// - OR combine: complete after any compare match.
// - AND combine: complete after every compare matches.
// - Depth zero disables FIFO, single conversion unit.
// - FIFO depth equals depth field plus one.
// - Conversions wait until channel FIFO reaches depth.
// - Completion only when result FIFO reaches depth.
// - Channel writes push, result low reads pop entries.
// - Results come out in channel write order.
`timescale 1ns/100ps
`default_nettype none
`include "afc_map.svh"

module afc_fifo_scan_ctrl
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   clk_en,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  output logic                        irq,
  output afc_pkg::afc_conv_req_t      conv_req,
  input  wire afc_pkg::afc_conv_rsp_t conv_rsp
);

  afc_pkg::afc_state_s_t s_q;
  afc_pkg::afc_state_s_t s_d;

  function automatic logic [3:0] afc_levels(input logic [7:0] fc);
    afc_levels = {1'b0, fc[`AFC_FC_DEP_MSB:`AFC_FC_DEP_LSB]} + 4'h1;
  endfunction

  function automatic logic afc_fifo_on(input logic [7:0] fc);
    afc_fifo_on = (fc[`AFC_FC_DEP_MSB:`AFC_FC_DEP_LSB] != 3'h0);
  endfunction

  logic [5:0]  idx;
  logic        aligned;
  logic        acc_first;
  logic        acc_done;
  logic        wr_done;
  logic        rd_done;
  logic        fifo_en;
  logic [3:0]  levels;
  logic        mapped;
  logic [31:0] rd_val;
  logic        ev_done;
  logic        ev_ovf;
  logic [`AFC_IRQ_WIDTH-1:0] w1c;
  logic        or_new;
  logic        and_new;
  logic        cmp_ok;
  logic        last;
  logic [2:0]  next_idx;

  assign idx       = paddr[7:2];
  assign aligned   = (paddr[1:0] == 2'h0);
  assign acc_first = psel & penable & ~s_q.pready;
  assign acc_done  = psel & penable & s_q.pready;
  assign wr_done   = acc_done & pwrite & ~s_q.pslverr;
  assign rd_done   = acc_done & ~pwrite & ~s_q.pslverr;
  assign fifo_en   = afc_fifo_on(s_q.fifo_ctrl);
  assign levels    = afc_levels(s_q.fifo_ctrl);

  // Register read multiplexer, captured in the first access cycle.
  always_comb
  begin
    mapped = aligned;
    rd_val = 32'h0000_0000;
    unique case (idx)
      `AFC_IDX_CTRL_ONE:
        rd_val = {24'h00_0000, s_q.conversion_complete_flag, s_q.ctrl_one[6:0]};
      `AFC_IDX_FIFO_CTRL:
        rd_val = {24'h00_0000, s_q.fifo_ctrl & `AFC_FC_WRITE_MASK};
      `AFC_IDX_RES_HIGH:
        rd_val = {28'h000_0000, s_q.res_mem[s_q.res_rd][11:8]};
      `AFC_IDX_RES_LOW:
        rd_val = {24'h00_0000, s_q.res_mem[s_q.res_rd][7:0]};
      `AFC_IDX_IRQ_STATUS:
        rd_val = {30'h0000_0000, s_q.irq_status};
      `AFC_IDX_IRQ_MASK:
        rd_val = {30'h0000_0000, s_q.irq_mask};
      default:
        mapped = 1'b0;
    endcase
  end

  // Next state of all registers, frozen while the clock enable is low.
  always_comb
  begin
    s_d      = s_q;
    ev_done  = 1'b0;
    ev_ovf   = 1'b0;
    w1c      = '0;
    or_new   = s_q.match_or | conv_rsp.match;
    and_new  = s_q.match_and & conv_rsp.match;
    cmp_ok   = 1'b1;
    last     = 1'b0;
    next_idx = 3'h0;
    if (clk_en)
    begin
      s_d.conv_req.start = 1'b0;
      s_d.pready = acc_first;
      if (acc_first)
      begin
        s_d.pslverr = ~mapped;
        s_d.prdata  = mapped ? rd_val : 32'h0000_0000;
      end

      if (wr_done && idx == `AFC_IDX_FIFO_CTRL)
      begin
        s_d.fifo_ctrl = pwdata[7:0] & `AFC_FC_WRITE_MASK;
        s_d.ch_cnt    = 4'h0;
      end
      if (wr_done && idx == `AFC_IDX_IRQ_MASK)
        s_d.irq_mask = pwdata[`AFC_IRQ_WIDTH-1:0];
      if (wr_done && idx == `AFC_IDX_IRQ_STATUS)
        w1c = pwdata[`AFC_IRQ_WIDTH-1:0];

      if (wr_done && idx == `AFC_IDX_CTRL_ONE)
      begin
        s_d.ctrl_one = pwdata[7:0] & 8'h7f;
        s_d.conversion_complete_flag     = 1'b0;
        if (fifo_en)
        begin
          if (s_q.ch_cnt < levels && s_q.state == afc_pkg::AFC_ST_IDLE)
          begin
            s_d.ch_mem[s_q.ch_cnt[2:0]] = pwdata[`AFC_C1_CH_MSB:`AFC_C1_CH_LSB];
            s_d.ch_cnt = s_q.ch_cnt + 4'h1;
          end
          else
            ev_ovf = 1'b1;
        end
        else
        begin
          s_d.ch_mem[0]        = pwdata[`AFC_C1_CH_MSB:`AFC_C1_CH_LSB];
          s_d.conv_req.channel = pwdata[`AFC_C1_CH_MSB:`AFC_C1_CH_LSB];
          s_d.conv_req.start   = 1'b1;
          s_d.state            = afc_pkg::AFC_ST_WAIT;
          s_d.res_rd           = 3'h0;
        end
      end

      if (rd_done && idx == `AFC_IDX_RES_LOW)
      begin
        s_d.conversion_complete_flag = 1'b0;
        // Pops wait for the set to end, so the write index stays intact.
        if (fifo_en && s_q.res_cnt != 4'h0 && s_q.state == afc_pkg::AFC_ST_IDLE)
        begin
          s_d.res_rd  = s_q.res_rd + 3'h1;
          s_d.res_cnt = s_q.res_cnt - 4'h1;
        end
      end

      unique case (s_q.state)
        afc_pkg::AFC_ST_IDLE:
        begin
          if (fifo_en && s_q.ch_cnt == levels)
          begin
            s_d.state            = afc_pkg::AFC_ST_WAIT;
            s_d.conv_idx         = 3'h0;
            s_d.res_cnt          = 4'h0;
            s_d.res_rd           = 3'h0;
            s_d.match_or         = 1'b0;
            s_d.match_and        = 1'b1;
            s_d.conv_req.channel = s_q.ch_mem[0];
            s_d.conv_req.start   = 1'b1;
          end
        end
        afc_pkg::AFC_ST_WAIT:
        begin
          if (conv_rsp.done)
          begin
            if (fifo_en)
            begin
              s_d.res_mem[s_q.res_cnt[2:0]] = conv_rsp.result;
              s_d.res_cnt   = s_q.res_cnt + 4'h1;
              s_d.match_or  = or_new;
              s_d.match_and = and_new;
              last = (s_q.res_cnt + 4'h1 == levels);
              if (s_q.ctrl_one[`AFC_C1_CMP_BIT])
                cmp_ok = s_q.fifo_ctrl[`AFC_FC_COMB_BIT] ? and_new : or_new;
              if (s_q.fifo_ctrl[`AFC_FC_SCAN_BIT])
                next_idx = 3'h0;
              else
                next_idx = s_q.conv_idx + 3'h1;
              if (!last)
              begin
                s_d.conv_idx         = next_idx;
                s_d.conv_req.channel = s_q.ch_mem[next_idx];
                s_d.conv_req.start   = 1'b1;
              end
              else
              begin
                s_d.conversion_complete_flag = cmp_ok;
                ev_done  = cmp_ok;
                if (s_q.ctrl_one[`AFC_C1_CONT_BIT])
                begin
                  s_d.conv_idx         = 3'h0;
                  s_d.res_cnt          = 4'h0;
                  s_d.res_rd           = 3'h0;
                  s_d.match_or         = 1'b0;
                  s_d.match_and        = 1'b1;
                  s_d.conv_req.channel = s_q.ch_mem[0];
                  s_d.conv_req.start   = 1'b1;
                end
                else
                begin
                  s_d.state  = afc_pkg::AFC_ST_IDLE;
                  s_d.ch_cnt = 4'h0;
                end
              end
            end
            else
            begin
              cmp_ok = ~s_q.ctrl_one[`AFC_C1_CMP_BIT] | conv_rsp.match;
              if (cmp_ok)
                s_d.res_mem[0] = conv_rsp.result;
              s_d.conversion_complete_flag = s_q.conversion_complete_flag | cmp_ok;
              ev_done  = cmp_ok;
              if (s_q.ctrl_one[`AFC_C1_CONT_BIT])
              begin
                s_d.conv_req.channel = s_q.ch_mem[0];
                s_d.conv_req.start   = 1'b1;
              end
              else
                s_d.state = afc_pkg::AFC_ST_IDLE;
            end
          end
        end
      endcase

      s_d.irq_status = (s_q.irq_status & ~w1c)
                     | {ev_ovf, ev_done};
      s_d.irq = |(s_d.irq_status & s_d.irq_mask);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q           <= '0;
      s_q.state     <= afc_pkg::AFC_ST_IDLE;
      s_q.fifo_ctrl <= `AFC_FC_RESET;
      s_q.ctrl_one  <= `AFC_C1_RESET;
      s_q.match_and <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign pready   = s_q.pready;
  assign prdata   = s_q.prdata;
  assign pslverr  = s_q.pslverr;
  assign irq      = s_q.irq;
  assign conv_req = s_q.conv_req;

endmodule

`default_nettype wire

// >>> dv/afc_fifo_scan_ctrl_sva.sv
/* Port checker of afc_fifo_scan_ctrl, bound below.
   Assumes clk_en high and no reset in mid-run. */
`timescale 1ns/100ps
`default_nettype none
module afc_fifo_scan_ctrl_sva
(
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [7:0]             paddr,
  input wire logic [31:0]            pwdata,
  input wire logic                   pready,
  input wire logic [31:0]            prdata,
  input wire logic                   irq,
  input wire afc_pkg::afc_conv_req_t conv_req
);
  logic       acc;
  logic       wr0;
  logic [2:0] dep_q;
  logic [3:0] cnt_q;
  assign acc = psel && penable && pready && pwrite;
  assign wr0 = acc && paddr == 8'h40;
  // Tracks the depth setting and the pushes made since it was written.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      dep_q <= 3'h0;
      cnt_q <= 4'h0;
    end
    else if (acc && paddr == 8'h4c)
    begin
      dep_q <= pwdata[2:0];
      cnt_q <= 4'h0;
    end
    else if (wr0 && cnt_q < 4'h9)
      cnt_q <= cnt_q + 4'h1;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_rsv;
    pready && !pwrite && paddr == 8'h4c |-> !(prdata & 32'hffffff98);
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved bit read as one");
  property p_ans;
    psel && penable && !pready |=> pready;
  endproperty
  a_ans: assert property (p_ans)
    else $error("bus answer late");
  property p_one;
    wr0 && dep_q == 3'h0 |-> ##[1:2] conv_req.start;
  endproperty
  a_one: assert property (p_one)
    else $error("single conversion not started");
  property p_hold;
    wr0 && dep_q != 3'h0 && cnt_q < {1'b0, dep_q} |=> !conv_req.start [*3];
  endproperty
  a_hold: assert property (p_hold)
    else $error("start before channel queue full");
  property p_go;
    wr0 && dep_q != 3'h0 && cnt_q == {1'b0, dep_q} |-> ##[1:3] conv_req.start;
  endproperty
  a_go: assert property (p_go)
    else $error("no start at full depth");
  property p_pls;
    conv_req.start |=> !conv_req.start;
  endproperty
  a_pls: assert property (p_pls)
    else $error("start wider than one cycle");
  property p_ch;
    !conv_req.start |-> $stable(conv_req.channel);
  endproperty
  a_ch: assert property (p_ch)
    else $error("channel moved without start");
  property p_msk;
    acc && paddr == 8'h84 && pwdata[1:0] == 2'h0 |=> ##1 !irq;
  endproperty
  a_msk: assert property (p_msk)
    else $error("masked interrupt raised");
endmodule
bind afc_fifo_scan_ctrl afc_fifo_scan_ctrl_sva u_sva (.*);
`default_nettype wire

// >>> dv/tb_top.sv
/* Bench of afc_fifo_scan_ctrl: APB master and converter core.
   Assumes the port checker is bound in. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic                   pclk = 1'b0;
  logic                   presetn = 1'b0;
  logic                   clk_en = 1'b1;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [7:0]             paddr = 8'h00;
  logic [31:0]            pwdata = 32'h0;
  logic [31:0]            prdata;
  logic [31:0]            rdat;
  logic                   pready, pslverr, irq, rerr;
  logic [1:0]             pend = 2'h0;
  afc_pkg::afc_conv_req_t conv_req;
  afc_pkg::afc_conv_rsp_t conv_rsp = '0;
  int                     failures = 0;
  int                     comparisons = 0;
  always #10 pclk = ~pclk;
  // Converter core: done three cycles after start, match on channel 1 only.
  always @(posedge pclk)
  begin
    pend <= {pend[0], conv_req.start};
    conv_rsp <= {pend[1], conv_req.channel == 5'h01, 7'h2a, conv_req.channel};
  end
  afc_fifo_scan_ctrl dut (.*);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20 && pready !== 1'b1; i++)
      @(posedge pclk);
    if (i == 20)
    begin
      failures++;
      finish_test;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wirq(input logic e);
    int i;
    for (i = 0; i < 60 && irq !== 1'b1; i++)
      @(posedge pclk);
    chk("irq", {31'h0, irq}, {31'h0, e});
    if (e && irq !== 1'b1)
      finish_test;
    apb(1'b1, 8'h80, 32'h3);
    @(posedge pclk);
    chk("irq_cleared", {31'h0, irq}, 32'h0);
  endtask
  task automatic rres(input logic [4:0] c);
    apb(1'b0, 8'h50, 32'h0);
    chk("result_high", rdat, 32'h5);
    apb(1'b0, 8'h54, 32'h0);
    chk("result_low", rdat, {24'h0, 3'h2, c});
  endtask
  task automatic t_reg;
    apb(1'b0, 8'h4c, 32'h0);
    chk("fifo_control_reset", rdat, 32'h0);
    apb(1'b1, 8'h4c, 32'hff);
    apb(1'b0, 8'h4c, 32'h0);
    chk("fifo_control", rdat, 32'h67);
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped", {31'h0, rerr}, 32'h1);
    apb(1'b1, 8'h4c, 32'h0);
    $display("t_reg done");
  endtask
  task automatic t_single;
    apb(1'b1, 8'h84, 32'h0);
    apb(1'b1, 8'h40, 32'h5);
    wirq(1'b0);
    rres(5'h05);
    apb(1'b1, 8'h84, 32'h1);
    apb(1'b1, 8'h40, 32'h4);
    wirq(1'b1);
    rres(5'h04);
    $display("t_single done");
  endtask
  task automatic t_set(input logic sc);
    apb(1'b1, 8'h4c, {25'h0, sc, 6'h02});
    apb(1'b1, 8'h40, 32'h3);
    apb(1'b1, 8'h40, 32'h7);
    apb(1'b1, 8'h40, 32'h9);
    wirq(1'b1);
    rres(5'h03);
    rres(sc ? 5'h03 : 5'h07);
    rres(sc ? 5'h03 : 5'h09);
    $display("t_set done");
  endtask
  task automatic t_cmp;
    logic [3:0] v;
    for (int k = 0; k < 4; k++)
    begin
      v = 4'(16'hfc05 >> (4 * k));
      apb(1'b1, 8'h4c, {26'h0, v[3], 5'h01});
      apb(1'b1, 8'h40, {25'h0, 5'h10, !v[2], v[2]});
      apb(1'b1, 8'h40, {25'h0, 5'h10, !v[1], v[1]});
      wirq(v[0]);
    end
    $display("t_cmp done");
  endtask
  task automatic t_cont;
    int i;
    apb(1'b1, 8'h4c, 32'h41);
    apb(1'b1, 8'h40, 32'h26);
    apb(1'b1, 8'h40, 32'h2b);
    for (i = 0; i < 60 && irq !== 1'b1; i++)
      @(posedge pclk);
    chk("restart_start", {31'h0, conv_req.start}, 32'h1);
    chk("restart_channel", {27'h0, conv_req.channel}, 32'h6);
    if (i == 60)
    begin
      failures++;
      finish_test;
    end
    apb(1'b1, 8'h40, 32'h6);
    apb(1'b0, 8'h80, 32'h0);
    chk("irq_status", rdat, 32'h3);
    wirq(1'b1);
    rres(5'h06);
    rres(5'h06);
    $display("t_cont done");
  endtask
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reg;
    t_single;
    t_set(1'b0);
    t_set(1'b1);
    t_cmp;
    t_cont;
    finish_test;
  end
endmodule
`default_nettype wire
